// ### pkg/rtc_pkg.sv
package rtc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] VALUE_WINDOW_IDX = 12'h624;
    localparam logic [11:0] CONFIG_IDX = 12'h626;
    localparam logic [11:0] UNLOCK_KEY_IDX = 12'h628;
    localparam logic [11:0] OSC_CTRL_IDX = 12'h62a;

    // Configuration register fields
    localparam int CFG_ENABLE_BIT = 15;
    localparam int CFG_WREN_BIT = 13;
    localparam int CFG_PTR_LSB = 8;
    localparam int CFG_CAL_LSB = 0;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Oscillator control fields
    localparam int OSC_SEC_EN_BIT = 1;
    localparam logic OSC_SEC_EN_RESET = 1'b0;

    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // Window pointer views
    localparam logic [1:0] PTR_MIN_SEC = 2'b00;
    localparam logic [1:0] PTR_WEEKDAY_DIGIT_HOUR = 2'b01;
    localparam logic [1:0] PTR_MONTH_DAY = 2'b10;
    localparam logic [1:0] PTR_YEAR = 2'b11;

    // Field maxima
    localparam logic [2:0] WEEKDAY_DIGIT_MAX = 3'h6;

    // Timing: one second of the time base
    localparam longint SECOND_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 10;
    localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT_FIRST = 2'b01,
        KEY_ARMED = 2'b10
    } key_state_t;

    typedef struct packed {
        logic [2:0] weekday_digit;
        logic [1:0] hour_tens_digit;
        logic [3:0] hour_ones_digit;
        logic [2:0] minute_tens_digit;
        logic [3:0] minute_ones_digit;
        logic [2:0] second_tens_digit;
        logic [3:0] second_ones_digit;
    } time_t;

    typedef struct packed {
        logic [7:0] year;
        logic [4:0] month;
        logic [5:0] day;
    } date_t;

endpackage

// ### hw/rtc_unlock.sv
module rtc_unlock
    import rtc_pkg::*;
(
    input wire logic clk,             // System clock
    input wire logic rst_n,           // Synchronous reset
    input wire logic key_wr,          // Completed write to key register
    input wire logic [7:0] key_data,  // Key value written
    input wire logic any_wr,          // Any completed bus write
    output logic armed                // Sequence just completed
);

    key_state_t state_q;
    key_state_t state_d;

    // Armed lasts for exactly one following write, so stray writes relock
    always_comb begin
        state_d = state_q;
        if (key_wr) begin
            if (key_data == KEY_FIRST) begin
                state_d = KEY_GOT_FIRST;
            end else if (key_data == KEY_SECOND && state_q == KEY_GOT_FIRST) begin
                state_d = KEY_ARMED;
            end else begin
                state_d = KEY_IDLE;
            end
        end else if (any_wr) begin
            state_d = KEY_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= KEY_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign armed = (state_q == KEY_ARMED);

endmodule

// ### hw/rtc_time_counter.sv
module rtc_time_counter
    import rtc_pkg::*;
(
    input wire logic clk,           // System clock
    input wire logic rst_n,         // Reset, only for checks
    input wire logic tick,          // One-second pulse
    input wire logic wr_min_sec,    // Load minutes/seconds view
    input wire logic wr_weekday_digit_hour,  // Load weekday/hours view
    input wire logic [15:0] wdata,  // View data
    output time_t now               // Current time
);

    time_t time_q;
    time_t time_d;

    // Loads win over a coincident tick; no reset, contents start unknown
    always_comb begin
        time_d = time_q;
        if (wr_min_sec) begin
            time_d.minute_tens_digit = wdata[14:12];
            time_d.minute_ones_digit = wdata[11:8];
            time_d.second_tens_digit = wdata[6:4];
            time_d.second_ones_digit = wdata[3:0];
        end else if (wr_weekday_digit_hour) begin
            time_d.weekday_digit = wdata[10:8];
            time_d.hour_tens_digit = wdata[5:4];
            time_d.hour_ones_digit = wdata[3:0];
        end else if (tick) begin
            time_d.second_ones_digit = time_q.second_ones_digit + 4'h1;
            if (time_q.second_ones_digit == 4'h9) begin
                time_d.second_ones_digit = 4'h0;
                time_d.second_tens_digit = time_q.second_tens_digit + 3'h1;
                if (time_q.second_tens_digit == 3'h5) begin
                    time_d.second_tens_digit = 3'h0;
                    time_d.minute_ones_digit = time_q.minute_ones_digit + 4'h1;
                    if (time_q.minute_ones_digit == 4'h9) begin
                        time_d.minute_ones_digit = 4'h0;
                        time_d.minute_tens_digit = time_q.minute_tens_digit + 3'h1;
                        if (time_q.minute_tens_digit == 3'h5) begin
                            time_d.minute_tens_digit = 3'h0;
                            time_d.hour_ones_digit = time_q.hour_ones_digit + 4'h1;
                            if (time_q.hour_tens_digit == 2'h2 && time_q.hour_ones_digit == 4'h3) begin
                                time_d.hour_tens_digit = 2'h0;
                                time_d.hour_ones_digit = 4'h0;
                                time_d.weekday_digit = time_q.weekday_digit + 3'h1;
                                if (time_q.weekday_digit >= WEEKDAY_DIGIT_MAX) begin
                                    time_d.weekday_digit = 3'h0;
                                end
                            end else if (time_q.hour_ones_digit == 4'h9) begin
                                time_d.hour_ones_digit = 4'h0;
                                time_d.hour_tens_digit = time_q.hour_tens_digit + 2'h1;
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        time_q <= time_d;
    end

    assign now = time_q;

    AST_SEC_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !wr_min_sec && !wr_weekday_digit_hour && time_q.second_ones_digit < 4'h9)
        |=> time_q.second_ones_digit == $past(time_q.second_ones_digit) + 4'h1)
        else $error("seconds did not advance on tick");

    AST_WEEKDAY_DIGIT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        (time_q.weekday_digit <= WEEKDAY_DIGIT_MAX && !wr_weekday_digit_hour) |=> time_q.weekday_digit <= WEEKDAY_DIGIT_MAX)
        else $error("weekday left its range");

endmodule

// ### hw/rtc_calendar_top.sv
module rtc_calendar_top
    import rtc_pkg::*;
#(
    parameter int SEC_CYCLES = SECOND_CYCLES  // Clock cycles per second
) (
    input wire logic clk,            // 100 MHz system clock
    input wire logic rst_n,          // Synchronous reset
    input wire logic psel,           // APB select
    input wire logic penable,        // APB enable
    input wire logic pwrite,         // APB direction
    input wire logic [15:0] paddr,   // APB byte address
    input wire logic [31:0] pwdata,  // APB write data
    output logic [31:0] prdata,      // APB read data
    output logic pready,             // APB ready
    output logic pslverr,            // APB error, unmapped only
    output logic running             // Clock is counting
);

    localparam int CNT_W = $clog2(SEC_CYCLES + 1);

    // Byte address of a register index
    function automatic logic [15:0] byte_addr(input logic [11:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction

    // Read image of the value window for a given pointer
    function automatic logic [15:0] view_word(
        input logic [1:0] ptr,
        input time_t t,
        input date_t d
    );
        view_word = 16'h0000;
        case (ptr)
            PTR_MIN_SEC: begin
                view_word[14:12] = t.minute_tens_digit;
                view_word[11:8] = t.minute_ones_digit;
                view_word[6:4] = t.second_tens_digit;
                view_word[3:0] = t.second_ones_digit;
            end
            PTR_WEEKDAY_DIGIT_HOUR: begin
                view_word[10:8] = t.weekday_digit;
                view_word[5:4] = t.hour_tens_digit;
                view_word[3:0] = t.hour_ones_digit;
            end
            PTR_MONTH_DAY: begin
                view_word[12:8] = d.month;
                view_word[5:0] = d.day;
            end
            PTR_YEAR: begin
                view_word[7:0] = d.year;
            end
            default: begin
                view_word = 16'h0000;
            end
        endcase
    endfunction

    // Bus answer state
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // Bus decode
    logic access;
    logic wr;
    logic hit_value;
    logic hit_config;
    logic hit_key;
    logic hit_osc;
    logic hit_any;
    logic armed;

    assign hit_value = (paddr == byte_addr(VALUE_WINDOW_IDX));
    assign hit_config = (paddr == byte_addr(CONFIG_IDX));
    assign hit_key = (paddr == byte_addr(UNLOCK_KEY_IDX));
    assign hit_osc = (paddr == byte_addr(OSC_CTRL_IDX));
    assign hit_any = hit_value | hit_config | hit_key | hit_osc;

    // Effects happen only at the edge that completes the access phase
    assign access = psel & penable & pready_q;
    assign wr = access & pwrite;

    // Configuration and oscillator state
    logic enable_q;
    logic enable_d;
    logic wren_q;
    logic wren_d;
    logic [1:0] ptr_q;
    logic [1:0] ptr_d;
    logic [7:0] cal_q;
    logic [7:0] cal_d;
    logic osc_en_q;
    logic osc_en_d;

    // Time base state
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic running_q;
    logic running_d;

    // Calendar state
    date_t date_q;
    date_t date_d;
    time_t now;

    logic cfg_wr;
    logic val_wr;
    logic wr_min_sec;
    logic wr_weekday_digit_hour;

    assign cfg_wr = wr & hit_config;

    // value writes pass only with write-enable set
    assign val_wr = wr & hit_value & wren_q;
    assign wr_min_sec = val_wr & (ptr_q == PTR_MIN_SEC);
    assign wr_weekday_digit_hour = val_wr & (ptr_q == PTR_WEEKDAY_DIGIT_HOUR);

    rtc_unlock rtc_unlock_inst (
        .clk(clk),
        .rst_n(rst_n),
        .key_wr(wr & hit_key),
        .key_data(pwdata[7:0]),
        .any_wr(wr),
        .armed(armed)
    );

    rtc_time_counter rtc_time_counter_inst (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_q),
        .wr_min_sec(wr_min_sec),
        .wr_weekday_digit_hour(wr_weekday_digit_hour),
        .wdata(pwdata[15:0]),
        .now(now)
    );

    // Configuration next state
    always_comb begin
        enable_d = enable_q;
        wren_d = wren_q;
        ptr_d = ptr_q;
        cal_d = cal_q;
        osc_en_d = osc_en_q;
        if (cfg_wr) begin
            ptr_d = pwdata[CFG_PTR_LSB +: 2];
            cal_d = pwdata[CFG_CAL_LSB +: 8];
            if (wren_q) begin
                enable_d = pwdata[CFG_ENABLE_BIT];
            end
            if (!pwdata[CFG_WREN_BIT]) begin
                wren_d = 1'b0;
            end else if (armed) begin
                wren_d = 1'b1;
            end
        end
        if (wr && hit_osc) begin
            osc_en_d = pwdata[OSC_SEC_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_q <= CFG_RESET[CFG_ENABLE_BIT];
            wren_q <= CFG_RESET[CFG_WREN_BIT];
            ptr_q <= CFG_RESET[CFG_PTR_LSB +: 2];
            cal_q <= CFG_RESET[CFG_CAL_LSB +: 8];
            osc_en_q <= OSC_SEC_EN_RESET;
        end else begin
            enable_q <= enable_d;
            wren_q <= wren_d;
            ptr_q <= ptr_d;
            cal_q <= cal_d;
            osc_en_q <= osc_en_d;
        end
    end

    // Date and year views, loaded like the time views
    always_comb begin
        date_d = date_q;
        if (val_wr && ptr_q == PTR_MONTH_DAY) begin
            date_d.month = pwdata[12:8];
            date_d.day = pwdata[5:0];
        end else if (val_wr && ptr_q == PTR_YEAR) begin
            date_d.year = pwdata[7:0];
        end
    end

    // no reset, so the calendar starts unknown
    always_ff @(posedge clk) begin
        date_q <= date_d;
    end

    // Time base: counts only while enabled and the oscillator runs
    always_comb begin
        running_d = enable_q & osc_en_q;
        cnt_d = cnt_q;
        tick_d = 1'b0;
        // one tick per second while running (enabled and oscillator on)
        if (running_q) begin
            if (cnt_q == CNT_W'(SEC_CYCLES - 1)) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            running_q <= running_d;
        end
    end

    // Bus answer: one wait state, read data captured with ready
    always_comb begin
        pready_d = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (pready_d) begin
            // only unmapped addresses raise an error
            pslverr_d = ~hit_any;
            if (!pwrite) begin
                // value register is a window chosen by the pointer
                if (hit_value) begin
                    prdata_d[15:0] = view_word(ptr_q, now, date_q);
                end else if (hit_config) begin
                    prdata_d[CFG_ENABLE_BIT] = enable_q;
                    prdata_d[CFG_WREN_BIT] = wren_q;
                    prdata_d[CFG_PTR_LSB +: 2] = ptr_q;
                    prdata_d[CFG_CAL_LSB +: 8] = cal_q;
                end else if (hit_osc) begin
                    prdata_d[OSC_SEC_EN_BIT] = osc_en_q;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign running = running_q;

    AST_BLOCKED_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && hit_value && !wren_q && !tick_q) |=> now == $past(now))
        else $error("time changed on a blocked write");

    AST_NO_VALUE_ERROR: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && !pready_q && hit_value) |=> pready && !pslverr)
        else $error("value access answered with error");

    // write-enable rises only after the keys
    AST_WREN_NEEDS_KEY: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(wren_q) |-> $past(armed && cfg_wr))
        else $error("write-enable set without key sequence");

    AST_WREN_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && !pwdata[CFG_WREN_BIT]) |=> !wren_q)
        else $error("write-enable did not clear");

    AST_ENABLE_GUARD: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(enable_q) |-> $past(wren_q))
        else $error("module enable changed while locked");

    AST_VIEW_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (pready_d && !pwrite && hit_value && ptr_q == PTR_WEEKDAY_DIGIT_HOUR)
        |=> prdata[15:11] == 5'h00 && prdata[7:6] == 2'h0)
        else $error("unused view bits not zero");

    // minute digits appear in their lanes
    AST_MINUTE_LANES: assert property (@(posedge clk) disable iff (!rst_n)
        (pready_d && !pwrite && hit_value && ptr_q == PTR_MIN_SEC && !tick_q)
        |=> prdata[14:8] == {now.minute_tens_digit, now.minute_ones_digit})
        else $error("minute digits misplaced");

    AST_STOPPED: assert property (@(posedge clk) disable iff (!rst_n)
        (!running_q)[*2] |-> !tick_q)
        else $error("tick while module disabled");

endmodule

// ### verif/rtc_write_guard_and_time_values_bench.sv
module rtc_write_guard_and_time_values_bench
    import rtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short second keeps the rollover run brief
    localparam int SEC_CYC = 20;
    localparam int LIMIT = 3000;
    localparam logic [15:0] A_VAL = 16'({VALUE_WINDOW_IDX, 2'b00});
    localparam logic [15:0] A_CFG = 16'({CONFIG_IDX, 2'b00});
    localparam logic [15:0] A_KEY = 16'({UNLOCK_KEY_IDX, 2'b00});
    localparam logic [15:0] A_OSC = 16'({OSC_CTRL_IDX, 2'b00});

    logic clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic running;
    logic [31:0] rdat;
    logic rerr;
    int bad_count;
    int cmp_count;
    int cycles = 0;

    rtc_calendar_top #(.SEC_CYCLES(SEC_CYC)) rtc_calendar_top_inst (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .running(running)
    );

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the hang guard ends a missing answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cfgv(input logic en, input logic we, input logic [1:0] ptr);
        logic [31:0] v;
        v = 32'h0;
        v[CFG_ENABLE_BIT] = en;
        v[CFG_WREN_BIT] = we;
        v[CFG_PTR_LSB +: 2] = ptr;
        return v;
    endfunction

    task automatic unlock(input logic [31:0] cfg);
        apb(1'b1, A_KEY, 32'(KEY_FIRST));
        apb(1'b1, A_KEY, 32'(KEY_SECOND));
        apb(1'b1, A_CFG, cfg);
    endtask

    // Reset state, unmapped access and the write-only key
    task automatic t_reset_map();
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, 32'(CFG_RESET));
        check(32'(running), 32'h0);
        apb(1'b0, 16'h1000, 32'h0);
        check(32'(rerr), 32'h1);
        apb(1'b0, A_KEY, 32'h0);
        check(rdat, 32'h0);
    endtask

    // Broken or reordered key sequences must not arm the write enable
    task automatic t_unlock();
        apb(1'b1, A_KEY, 32'(KEY_FIRST));
        apb(1'b1, A_OSC, 32'h0);
        apb(1'b1, A_KEY, 32'(KEY_SECOND));
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b1, PTR_MIN_SEC));
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, 32'h0);
        apb(1'b1, A_KEY, 32'(KEY_SECOND));
        apb(1'b1, A_KEY, 32'(KEY_FIRST));
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b1, PTR_MIN_SEC));
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, 32'h0);
        unlock(cfgv(1'b0, 1'b1, PTR_MIN_SEC));
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, cfgv(1'b0, 1'b1, PTR_MIN_SEC));
    endtask

    // Loads with junk in unused bits, then a full BCD rollover
    task automatic t_load_count();
        int n;
        apb(1'b1, A_VAL, 32'h0000_d9d9);
        check(32'(rerr), 32'h0);
        apb(1'b0, A_VAL, 32'h0);
        check(rdat, 32'h0000_5959);
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b1, PTR_WEEKDAY_DIGIT_HOUR));
        apb(1'b1, A_VAL, 32'h0000_fee3);
        apb(1'b0, A_VAL, 32'h0);
        check(rdat, 32'h0000_0623);
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b1, PTR_MONTH_DAY));
        apb(1'b1, A_VAL, 32'h0000_f2f1);
        apb(1'b0, A_VAL, 32'h0);
        check(rdat, 32'h0000_1231);
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b1, PTR_YEAR));
        apb(1'b1, A_VAL, 32'h0000_ff99);
        apb(1'b0, A_VAL, 32'h0);
        check(rdat, 32'h0000_0099);
        apb(1'b1, A_OSC, 32'h0000_0002);
        apb(1'b0, A_OSC, 32'h0);
        check(rdat, 32'h0000_0002);
        apb(1'b1, A_CFG, cfgv(1'b1, 1'b1, PTR_WEEKDAY_DIGIT_HOUR));
        n = 0;
        while (running !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        check(32'(running), 32'h1);
        // Exactly one tick falls inside this wait
        repeat (SEC_CYC + 4) @(posedge clk);
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b1, PTR_WEEKDAY_DIGIT_HOUR));
        apb(1'b0, A_VAL, 32'h0);
        check(rdat, 32'h0);
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b1, PTR_MIN_SEC));
        apb(1'b0, A_VAL, 32'h0);
        check(rdat, 32'h0);
    endtask

    // Clearing write enable blocks time and enable changes
    task automatic t_guard();
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b0, PTR_MIN_SEC));
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, 32'h0);
        apb(1'b1, A_VAL, 32'h0000_1234);
        check(32'(rerr), 32'h0);
        apb(1'b0, A_VAL, 32'h0);
        check(rdat, 32'h0);
        apb(1'b1, A_CFG, cfgv(1'b1, 1'b0, PTR_MIN_SEC));
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, 32'h0);
        check(32'(running), 32'h0);
        // Setting both bits in one write leaves the enable alone
        unlock(cfgv(1'b1, 1'b1, PTR_MIN_SEC));
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, cfgv(1'b0, 1'b1, PTR_MIN_SEC));
        apb(1'b1, A_CFG, cfgv(1'b1, 1'b1, PTR_MIN_SEC));
        apb(1'b1, A_CFG, cfgv(1'b1, 1'b0, PTR_MIN_SEC));
        apb(1'b1, A_CFG, cfgv(1'b0, 1'b0, PTR_MIN_SEC));
        apb(1'b0, A_CFG, 32'h0);
        check(rdat, cfgv(1'b1, 1'b0, PTR_MIN_SEC));
        check(32'(running), 32'h1);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        bad_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_map();
        t_unlock();
        t_load_count();
        t_guard();
        stop_test();
    end
endmodule
